// File: qtmr_cfg.svh
// constants of the quad timer output-enable and reload register block
`ifndef QTMR_CFG_SVH
`define QTMR_CFG_SVH
`define QTMR_IDX_CTRL 8'hC8
`define QTMR_IDX_MODE0 8'hC9
`define QTMR_IDX_MODE1 8'hCA
`define QTMR_IDX_OE 8'hCB
`define QTMR_IDX_A_LO 8'hCC
`define QTMR_IDX_A_HI 8'hCD
`define QTMR_IDX_B_LO 8'hCE
`define QTMR_IDX_B_HI 8'hCF
`define QTMR_IDX_C_LO 8'hD4
`define QTMR_IDX_C_HI 8'hD5
`define QTMR_IDX_D_LO 8'hD6
`define QTMR_IDX_D_HI 8'hD7
`define QTMR_RST_BYTE 8'h00
`define QTMR_RST_PIN_OE_N 8'hFF
`define QTMR_CTRL_RUN_LSB 0
`define QTMR_CTRL_FLAG_LSB 4
`define QTMR_MODE_LO_BIT 3
`define QTMR_MODE_HI_BIT 7
`define QTMR_PWM_TOP 16'hFFFF
`define QTMR_DIV_MASK0 10'h000
`define QTMR_DIV_MASK1 10'h001
`define QTMR_DIV_MASK2 10'h007
`define QTMR_DIV_MASK3 10'h00F
`define QTMR_DIV_MASK4 10'h03F
`define QTMR_DIV_MASK5 10'h07F
`define QTMR_DIV_MASK6 10'h1FF
`define QTMR_DIV_MASK7 10'h3FF
`endif

// File: qtmr_pkg.sv
// types of the quad timer output-enable and reload register block
package qtmr_pkg;
  // per-channel settings handed to a counter
  typedef struct packed {
    logic run;
    logic mode;
    logic [2:0] psel;
    logic [15:0] reload;
  } qtmr_chan_cfg_t;
  // per-channel results from a counter
  typedef struct packed {
    logic wave1;
    logic wave2;
    logic evt;
  } qtmr_chan_st_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic [9:0] pre;
    logic wave1;
    logic wave2;
    logic evt;
  } qtmr_cnt_state_t;
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0][7:0] reload;
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [7:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin;
    logic [7:0] pin_oe_n;
  } qtmr_top_state_t;
endpackage

// File: qtmr_counter.sv
// one down-counting timer channel with prescaler, reload and pwm
`timescale 1ns/100ps
`default_nettype none
`include "qtmr_cfg.svh"
module qtmr_counter #(
  parameter int CNT_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire qtmr_pkg::qtmr_chan_cfg_t i_cfg,
  output qtmr_pkg::qtmr_chan_st_t o_st
);
  qtmr_pkg::qtmr_cnt_state_t s_q;
  qtmr_pkg::qtmr_cnt_state_t s_d;
  logic [9:0] mask;
  logic tick;

  // the reload path is exactly two bytes wide
  if (CNT_W != 16)
  begin : g_bad_width
    $error("qtmr_counter serves only a 16-bit counter");
  end

  // prescaler mask per divider code
  always_comb
  begin
    case (i_cfg.psel)
      3'd0: mask = `QTMR_DIV_MASK0;
      3'd1: mask = `QTMR_DIV_MASK1;
      3'd2: mask = `QTMR_DIV_MASK2;
      3'd3: mask = `QTMR_DIV_MASK3;
      3'd4: mask = `QTMR_DIV_MASK4;
      3'd5: mask = `QTMR_DIV_MASK5;
      3'd6: mask = `QTMR_DIV_MASK6;
      default: mask = `QTMR_DIV_MASK7;
    endcase
  end

  assign tick = i_cfg.run && ((s_q.pre & mask) == mask);

  // counting: a stopped channel holds its start count, prescaler and outputs clear
  always_comb
  begin
    s_d = s_q;
    s_d.evt = 1'b0;
    if (!i_cfg.run)
    begin
      s_d.pre = 10'h000;
      s_d.cnt = i_cfg.mode ? `QTMR_PWM_TOP : i_cfg.reload;
      s_d.wave1 = 1'b0;
    end
    else
    begin
      s_d.pre = s_q.pre + 10'h001;
      if (tick)
      begin
        if (s_q.cnt == 16'h0000)
        begin
          s_d.evt = 1'b1;
          // reload value or the pwm top, per mode
          s_d.cnt = i_cfg.mode ? `QTMR_PWM_TOP : i_cfg.reload;
          if (!i_cfg.mode)
            s_d.wave1 = ~s_q.wave1;
        end
        else
          s_d.cnt = s_q.cnt - 16'h0001;
        // pwm: high while count is below the duty value
        if (i_cfg.mode)
          s_d.wave1 = (s_d.cnt < i_cfg.reload);
      end
    end
    s_d.wave2 = i_cfg.run & ~s_d.wave1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_st.wave1 = s_q.wave1;
  assign o_st.wave2 = s_q.wave2;
  assign o_st.evt = s_q.evt;

  a_zero_event: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (tick && s_q.cnt == 16'h0000) |=> s_q.evt)
    else $error("zero count did not raise the event");

  a_stop_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_cfg.run |=> (!s_q.wave1 && !s_q.wave2 && !s_q.evt))
    else $error("stopped channel still produces activity");

  a_auto_reload: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (tick && !i_cfg.mode && s_q.cnt == 16'h0000) |=>
      s_q.cnt == $past(i_cfg.reload))
    else $error("auto-reload did not restore the reload value");

  a_pwm_duty: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (tick && i_cfg.mode) |=>
      s_q.wave1 == (s_q.cnt < $past(i_cfg.reload)))
    else $error("pwm wave does not follow the duty value");

  c_reload_evt: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_cfg.mode && s_q.evt);
  c_pwm_evt: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_cfg.mode && s_q.evt);
endmodule
`default_nettype wire

// File: qtmr_regs.sv
// quad timer register file on apb with output enables and pin drive
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "qtmr_cfg.svh"
module qtmr_regs #(
  parameter int PADDR_W = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [7:0] o_pin,
  output logic [7:0] o_pin_oe_n
);
  qtmr_pkg::qtmr_top_state_t s_q;
  qtmr_pkg::qtmr_top_state_t s_d;
  qtmr_pkg::qtmr_chan_cfg_t cfg [4];
  qtmr_pkg::qtmr_chan_st_t st [4];
  logic [7:0] idx;
  logic aligned;
  logic mapped;
  logic wr_done;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [3:0] evt;
  logic [7:0] wave;

  // reset leaves every pin with its port function, enables all clear
  localparam qtmr_pkg::qtmr_top_state_t RST_STATE =
    '{pin_oe_n: `QTMR_RST_PIN_OE_N, default: '0};

  // index in bits 9:2 plus a must-be-zero field above it
  if (PADDR_W < 11)
  begin : g_bad_addr_w
    $error("qtmr_regs needs at least eleven address bits");
  end

  // word index, byte address is four times the index
  assign idx = i_paddr[9:2];
  assign aligned = (i_paddr[1:0] == 2'b00) &&
    (i_paddr[PADDR_W-1:10] == '0);
  assign wbyte = i_pwdata[7:0];
  assign wr_done = i_psel && i_penable && s_q.pready && i_pwrite &&
    i_pstrb[0] && mapped;

  // address decode and read mux
  always_comb
  begin
    mapped = aligned;
    rbyte = 8'h00;
    case (idx)
      `QTMR_IDX_CTRL: rbyte = s_q.ctrl;
      `QTMR_IDX_MODE0: rbyte = s_q.mode0;
      `QTMR_IDX_MODE1: rbyte = s_q.mode1;
      `QTMR_IDX_OE: rbyte = s_q.oe;
      `QTMR_IDX_A_LO: rbyte = s_q.reload[0];
      `QTMR_IDX_A_HI: rbyte = s_q.reload[1];
      `QTMR_IDX_B_LO: rbyte = s_q.reload[2];
      `QTMR_IDX_B_HI: rbyte = s_q.reload[3];
      `QTMR_IDX_C_LO: rbyte = s_q.reload[4];
      `QTMR_IDX_C_HI: rbyte = s_q.reload[5];
      `QTMR_IDX_D_LO: rbyte = s_q.reload[6];
      `QTMR_IDX_D_HI: rbyte = s_q.reload[7];
      default: mapped = 1'b0;
    endcase
  end

  // channel settings; each reload pair is high byte over low byte
  always_comb
  begin
    cfg[0].reload = {s_q.reload[1], s_q.reload[0]};
    cfg[1].reload = {s_q.reload[3], s_q.reload[2]};
    cfg[2].reload = {s_q.reload[5], s_q.reload[4]};
    cfg[3].reload = {s_q.reload[7], s_q.reload[6]};
    cfg[0].mode = s_q.mode0[`QTMR_MODE_LO_BIT];
    cfg[1].mode = s_q.mode0[`QTMR_MODE_HI_BIT];
    cfg[2].mode = s_q.mode1[`QTMR_MODE_LO_BIT];
    cfg[3].mode = s_q.mode1[`QTMR_MODE_HI_BIT];
    cfg[0].psel = s_q.mode0[2:0];
    cfg[1].psel = s_q.mode0[6:4];
    cfg[2].psel = s_q.mode1[2:0];
    cfg[3].psel = s_q.mode1[6:4];
    for (int c = 0; c < 4; c++)
      cfg[c].run = s_q.ctrl[`QTMR_CTRL_RUN_LSB + c];
  end

  // one counter per channel, waves land on pin pairs
  for (genvar g = 0; g < 4; g++)
  begin : g_chan
    qtmr_counter #(
      .CNT_W(16)
    ) u_cnt (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_cfg(cfg[g]),
      .o_st(st[g])
    );
    assign evt[g] = st[g].evt;
    assign wave[2*g] = st[g].wave1;
    assign wave[2*g+1] = st[g].wave2;
  end

  // bus answer, register writes, flags and pin drive
  always_comb
  begin
    s_d = s_q;
    // one wait state so read data comes from a flop
    s_d.pready = i_psel && i_penable && !s_q.pready;
    s_d.pslverr = i_psel && i_penable && !s_q.pready && !mapped;
    s_d.prdata = (i_psel && i_penable && !s_q.pready && mapped && !i_pwrite) ?
      {24'h00_0000, rbyte} : 32'h0000_0000;
    if (wr_done)
    begin
      case (idx)
        `QTMR_IDX_CTRL: s_d.ctrl = wbyte;
        `QTMR_IDX_MODE0: s_d.mode0 = wbyte;
        `QTMR_IDX_MODE1: s_d.mode1 = wbyte;
        `QTMR_IDX_OE: s_d.oe = wbyte;
        // a write while the channel runs is not blocked: result undefined
        `QTMR_IDX_A_LO: s_d.reload[0] = wbyte;
        `QTMR_IDX_A_HI: s_d.reload[1] = wbyte;
        `QTMR_IDX_B_LO: s_d.reload[2] = wbyte;
        `QTMR_IDX_B_HI: s_d.reload[3] = wbyte;
        `QTMR_IDX_C_LO: s_d.reload[4] = wbyte;
        `QTMR_IDX_C_HI: s_d.reload[5] = wbyte;
        `QTMR_IDX_D_LO: s_d.reload[6] = wbyte;
        `QTMR_IDX_D_HI: s_d.reload[7] = wbyte;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // a zero event beats a software clear in the same cycle
    s_d.ctrl[`QTMR_CTRL_FLAG_LSB +: 4] =
      s_d.ctrl[`QTMR_CTRL_FLAG_LSB +: 4] | evt;
    // disabled outputs release the pin and drive low
    s_d.pin_oe_n = ~s_d.oe;
    s_d.pin = wave & s_d.oe;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      s_q <= RST_STATE;
    else
      s_q <= s_d;
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_pin = s_q.pin;
  assign o_pin_oe_n = s_q.pin_oe_n;

  // per-pin enable check
  for (genvar p = 0; p < 8; p++)
  begin : g_pin_chk
    a_pin_gate: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_pin_oe_n[p] == !s_q.oe[p]) && (!s_q.oe[p] -> !o_pin[p]))
      else $error("output pin driven while its enable is clear");
  end

  a_oe_chd_out2: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (wr_done && idx == `QTMR_IDX_OE) |=> (o_pin_oe_n[7] == !$past(wbyte[7])))
    else $error("channel d out2 enable not applied");

  a_oe_chd_out1: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !s_q.oe[6] |-> o_pin_oe_n[6] && !o_pin[6])
    else $error("channel d out1 driven while disabled");

  a_oe_chc_pair: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (s_q.oe[5:4] == 2'b00) |-> (o_pin_oe_n[5:4] == 2'b11))
    else $error("channel c outputs driven while disabled");

  a_oe_chc_out1: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_q.oe[4] && st[2].wave1 |=> o_pin[4] || !$past(s_d.oe[4]))
    else $error("channel c out1 wave not passed to pin");

  a_oe_chb_pair: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_q.oe[3:2] == 2'b11 |-> o_pin_oe_n[3:2] == 2'b00)
    else $error("channel b outputs not driven while enabled");

  a_oe_chb_out1: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(s_q.oe[2]) |-> $fell(o_pin_oe_n[2]))
    else $error("channel b out1 enable edge not mirrored");

  a_oe_cha_out2: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $fell(s_q.oe[1]) |-> $rose(o_pin_oe_n[1]) && !o_pin[1])
    else $error("channel a out2 not released on disable");

  a_oe_cha_out1: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !s_q.oe[0] [*2] |-> !o_pin[0] && o_pin_oe_n[0])
    else $error("channel a out1 driven while disabled");

  a_reload_write: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (wr_done && idx == `QTMR_IDX_A_LO) |=>
      cfg[0].reload[7:0] == $past(wbyte))
    else $error("channel a low reload byte not stored");

  a_reload_high: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (wr_done && idx == `QTMR_IDX_D_HI) |=>
      cfg[3].reload[15:8] == $past(wbyte))
    else $error("channel d high reload byte not stored");

  a_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    evt[1] |=> s_q.ctrl[`QTMR_CTRL_FLAG_LSB + 1])
    else $error("channel b flag not set by its event");

  a_bus_answer: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_psel && i_penable && !o_pready) |=> o_pready)
    else $error("bus answer not given after one wait state");

  a_oe_keep: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !(wr_done && idx == `QTMR_IDX_OE) |=> s_q.oe == $past(s_q.oe))
    else $error("output enables changed without a register write");

  a_flag_race: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (evt[0] && wr_done && idx == `QTMR_IDX_CTRL) |=>
      s_q.ctrl[`QTMR_CTRL_FLAG_LSB])
    else $error("software clear beat a channel a zero event");

  a_read_reload: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_psel && i_penable && !s_q.pready && !i_pwrite && aligned &&
      idx == `QTMR_IDX_B_HI) |=>
      o_prdata == {24'h00_0000, $past(s_q.reload[3])})
    else $error("channel b high reload byte read back wrong");

  c_pin_live: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !o_pin_oe_n[0] && o_pin[0]);
  c_unmapped: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_pready && o_pslverr);
  c_flag_race: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    wr_done && idx == `QTMR_IDX_CTRL && evt != 4'h0);
endmodule
`default_nettype wire

// File: qtmr_pin_model.sv
// pin-side model: each timer pin resolved against its ordinary port function
`timescale 1ns/100ps
`default_nettype none
module qtmr_pin_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_pin_oe_n,
  output logic [7:0] o_pad,
  output logic [7:0] o_port
);
  // port function flips every cycle so a stale timer value never passes
  always @(posedge i_sys_clk)
  begin
    o_port <= (o_port === 8'h5a) ? 8'ha5 : 8'h5a;
  end
  // timer owns the pad only while its enable is set
  assign o_pad = (i_pin & ~i_pin_oe_n) | (o_port & i_pin_oe_n);
endmodule
`default_nettype wire

// File: qtmr_regs_tb.sv
// self-checking bench for the quad timer register block
`timescale 1ns/100ps
`default_nettype none
module qtmr_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin;
  logic [7:0] pin_oe_n;
  logic [7:0] pad;
  logic [7:0] port;
  logic [31:0] r;
  logic e;
  int fail_count = 0;
  int checks = 0;
  int mdl[int];
  int regs[$] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce,
    8'hcf, 8'hd4, 8'hd5, 8'hd6, 8'hd7};
  always #2 clk = ~clk;
  qtmr_regs dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_pin(pin),
    .o_pin_oe_n(pin_oe_n));
  qtmr_pin_model pin_u (.i_sys_clk(clk), .i_pin(pin), .i_pin_oe_n(pin_oe_n),
    .o_pad(pad), .o_port(port));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer, called just after a rising edge; the answer is read
  // at rising edges only, before that edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
      chk("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input int i, input logic [7:0] v);
    apb(1'b1, 12'(i * 4), v, 4'h1);
    mdl[i] = v;
    chk("wr_err", 0, 32'(e));
  endtask
  task automatic rd(input int i);
    apb(1'b0, 12'(i * 4), 8'h00, 4'h0);
    chk($sformatf("reg_%h", i), mdl[i], r);
    chk("rd_err", 0, 32'(e));
  endtask
  // pins against the enable model: timer where enabled, port elsewhere
  task automatic padchk(input int cyc);
    logic [7:0] oe;
    oe = 8'(mdl[8'hcb]);
    repeat (cyc)
    begin
      @(negedge clk);
      chk("oe_n", {24'h00_0000, ~oe}, {24'h00_0000, pin_oe_n});
      chk("pin_off", 0, {24'h00_0000, pin & ~oe});
      chk("pad", {24'h00_0000, (pin & oe) | (port & ~oe)},
        {24'h00_0000, pad});
    end
    @(posedge clk);
  endtask
  initial
  begin
    int tog;
    logic last;
    logic [7:0] v;
    void'($urandom(32'hc178_0cef));
    foreach (regs[k]) mdl[regs[k]] = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("oe_n_rst", 8'hff, 32'(pin_oe_n));
    chk("pin_rst", 0, 32'(pin));
    @(posedge clk);
    foreach (regs[k]) rd(regs[k]);
    $display("test reset done");
    for (int i = 4; i < 12; i++) wr(regs[i], 8'($urandom));
    foreach (regs[k]) rd(regs[k]);
    apb(1'b1, 12'h330, 8'h5a, 4'h0);
    rd(8'hcc);
    apb(1'b0, 12'h340, 8'h00, 4'h0);
    chk("unmapped_err", 1, 32'(e));
    chk("unmapped_data", 0, r);
    apb(1'b1, 12'h335, 8'hff, 4'h1);
    chk("misaligned_err", 1, 32'(e));
    rd(8'hcd);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hcb, 8'(1 << i));
      chk("oe_n", {24'h00_0000, ~8'(1 << i)},
        {24'h00_0000, pin_oe_n});
      padchk(2);
    end
    $display("test enables done");
    for (int i = 4; i < 12; i++) wr(regs[i], (i % 2) ? 8'h00 : 8'h03);
    wr(8'hc9, 8'h00);
    wr(8'hca, 8'h00);
    wr(8'hcb, 8'hff);
    wr(8'hc8, 8'h0f);
    tog = 0;
    last = pin[0];
    repeat (60)
    begin
      @(negedge clk);
      if (pin[0] !== last)
        tog++;
      last = pin[0];
    end
    chk("toggles", 1, 32'(tog >= 8 && tog <= 20));
    chk("wave2", 32'({~pin[6], ~pin[4], ~pin[2], ~pin[0]}),
      32'({pin[7], pin[5], pin[3], pin[1]}));
    @(posedge clk);
    mdl[8'hc8] = 8'hff;
    rd(8'hc8);
    v = 8'($urandom);
    wr(8'hcb, v);
    chk("oe_n_run", {24'h00_0000, ~v},
      {24'h00_0000, pin_oe_n});
    padchk(20);
    wr(8'hc8, 8'hf0);
    rd(8'hc8);
    wr(8'hc8, 8'h00);
    rd(8'hc8);
    $display("test auto reload done");
    for (int i = 4; i < 12; i++) wr(regs[i], 8'h00);
    wr(8'hc9, 8'h88);
    wr(8'hca, 8'h88);
    wr(8'hcb, 8'hff);
    wr(8'hc8, 8'h0f);
    repeat (100)
    begin
      @(negedge clk);
      chk("duty_zero", 0, 32'(pin & 8'h55));
    end
    @(posedge clk);
    wr(8'hc8, 8'h00);
    for (int i = 4; i < 12; i++) wr(regs[i], 8'hff);
    wr(8'hc8, 8'h0f);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk("duty_full", 8'h55, 32'(pin & 8'h55));
    $display("test pwm done");
    // reset in mid-run: pins go back to the port at the first clock edge in reset, registers clear
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("oe_n_in_rst", 8'hff, {24'h00_0000, pin_oe_n});
    chk("pin_in_rst", 0, {24'h00_0000, pin});
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[k]) mdl[regs[k]] = 0;
    @(posedge clk);
    @(negedge clk);
    chk("oe_n_rst2", 8'hff, {24'h00_0000, pin_oe_n});
    @(posedge clk);
    foreach (regs[k]) rd(regs[k]);
    $display("test mid-run reset done");
    conclude();
  end
  // cut a hang short well past the expected run length
  initial
  begin
    #100000;
    chk("watchdog", 0, 1);
    conclude();
  end
endmodule
`default_nettype wire
